// *** logic/drf_refresh_sched.sv ***
// Device-side refresh command decoder and per-bank refresh scheduler.
// Assumes command pins are synchronous to i_clk and the controller keeps
// its own spacing; the device only tracks and reports what it is doing.
`timescale 1ns/10ps
// Functional notes
// - Refresh is chip select low, bit0 low, bit1 low, bit2 high.
// - Bit3 low means per-bank refresh, bit3 high means all-bank.
// - Per-bank refresh hits counter bank, counter steps 0..7 and wraps.
// - Counter clears on reset command and on self refresh exit.
// - All-bank refresh also clears the bank counter.
// - Only the refreshed bank is busy; other banks stay usable.
// - After per-bank refresh cycle, the refreshed bank is idle.
// - After all-bank cycle all banks idle; controller waits full time.
module drf_refresh_sched (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_cs_n,
  input  wire logic [3:0] i_cmd_addr,
  input  wire logic       i_reset_cmd,
  input  wire logic       i_self_refresh_exit,
  output logic [2:0]      o_bank_counter,
  output logic [7:0]      o_bank_busy,
  output logic            o_all_refresh_busy,
  output logic            o_per_bank_refresh,
  output logic            o_all_bank_refresh
);
  typedef enum logic [1:0] {DRF_IDLE, DRF_ALL_BUSY} drf_state_e;

  // All checks below share this clock and stay quiet during reset
  default clocking drf_cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  drf_state_e  state_r;
  logic [2:0]  bank_r;
  wire  [7:0]  busy_w;
  logic [7:0]  start_w;
  logic [7:0]  all_cnt_r;
  logic [7:0]  busy_r;
  logic        all_busy_r;
  logic        pb_pulse_r;
  logic        ab_pulse_r;
  logic        is_ref;
  logic        is_pb;
  logic        is_ab;

  // Bank step with wrap after the last bank
  function automatic logic [2:0] drf_next_bank(input logic [2:0] b);
    drf_next_bank = (b == drf_pkg::BANK_LAST) ? drf_pkg::BANK_RESET
                                              : 3'(b + 3'h1);
  endfunction

  // ==========================================================================
  // Command decode
  // Refresh pattern on the rising edge
  assign is_ref = !i_cs_n && !i_cmd_addr[drf_pkg::CA_BIT0]
                  && !i_cmd_addr[drf_pkg::CA_BIT1]
                  && i_cmd_addr[drf_pkg::CA_BIT2];
  assign is_pb = is_ref && !i_cmd_addr[drf_pkg::CA_BIT3];
  assign is_ab = is_ref && i_cmd_addr[drf_pkg::CA_BIT3];

  // ==========================================================================
  // Bank counter
  // Clears win over stepping so the controller copy stays aligned
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bank_r <= drf_pkg::BANK_RESET;
    end else if (i_reset_cmd || i_self_refresh_exit) begin
      bank_r <= drf_pkg::BANK_RESET;
    end else if (is_ab) begin
      bank_r <= drf_pkg::BANK_RESET;
    end else if (is_pb) begin
      bank_r <= drf_next_bank(bank_r);
    end
  end

  // ==========================================================================
  // Per-bank timers; only the targeted bank starts, others stay usable
  // One-hot start for the bank the counter points at; the other banks keep
  // running, since only the refreshed bank is taken out of service
  assign start_w = is_pb ? (8'h01 << bank_r) : 8'h00;
  genvar g;
  generate
    for (g = 0; g < drf_pkg::NUM_BANKS; g++) begin : g_bank
      drf_bank_timer u_timer (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_start   (start_w[g]),
        .i_count   (drf_pkg::RFC_BANK_CNT),
        .o_busy    (busy_w[g])
      );
    end
  endgenerate

  // ==========================================================================
  // All-bank refresh cycle tracking
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r   <= DRF_IDLE;
      all_cnt_r <= 8'h00;
    end else begin
      case (state_r)
        DRF_IDLE: begin
          if (is_ab) begin
            state_r   <= DRF_ALL_BUSY;
            all_cnt_r <= drf_pkg::RFC_ALL_CNT;
          end
        end
        DRF_ALL_BUSY: begin
          if (all_cnt_r == 8'h01) begin
            state_r   <= DRF_IDLE;
            all_cnt_r <= 8'h00;
          end else begin
            all_cnt_r <= all_cnt_r - 8'h01;
          end
        end
        default: begin
          state_r   <= DRF_IDLE;
          all_cnt_r <= 8'h00;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registered outputs
  // Busy bits drop when a timer ends, leaving the bank idle
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      busy_r     <= 8'h00;
      all_busy_r <= 1'b0;
      pb_pulse_r <= 1'b0;
      ab_pulse_r <= 1'b0;
    end else begin
      busy_r     <= busy_w | start_w;
      // Command edge is the first busy cycle, so drop after the last count
      all_busy_r <= ((state_r == DRF_ALL_BUSY) && (all_cnt_r != 8'h01))
                    || is_ab;
      pb_pulse_r <= is_pb;
      ab_pulse_r <= is_ab;
    end
  end

  assign o_bank_counter     = bank_r;
  assign o_bank_busy        = busy_r;
  assign o_all_refresh_busy = all_busy_r;
  assign o_per_bank_refresh = pb_pulse_r;
  assign o_all_bank_refresh = ab_pulse_r;

  // ==========================================================================
  // Checks
  // Per-bank command that no counter clear overrides
  sequence pb_cmd_s;
    !i_cs_n && i_cmd_addr == 4'h4 && !i_reset_cmd && !i_self_refresh_exit;
  endsequence
  // Same command aimed at the last bank, where the counter must wrap
  sequence pb_last_s;
    pb_cmd_s ##0 (bank_r == drf_pkg::BANK_LAST);
  endsequence
  // A refreshed bank is out for the per-bank cycle, then idle again
  sequence pb_cycle0_s;
    o_bank_busy[0] [*3] ##1 !o_bank_busy[0];
  endsequence
  sequence pb_cycle7_s;
    o_bank_busy[7] [*3] ##1 !o_bank_busy[7];
  endsequence
  // Whole device out for the all-bank cycle, then idle
  sequence ab_cycle_s;
    o_all_refresh_busy [*6] ##1 !o_all_refresh_busy;
  endsequence

  bank_step_a: assert property (
    pb_cmd_s |=> bank_r == drf_next_bank($past(bank_r)))
    else $error("bank counter did not step");
  bank_wrap_a: assert property (
    pb_last_s |=> bank_r == drf_pkg::BANK_RESET)
    else $error("bank counter did not wrap");
  bank_hold_a: assert property (
    (!is_pb && !is_ab && !i_reset_cmd && !i_self_refresh_exit)
      |=> $stable(bank_r))
    else $error("bank counter moved without a command");
  ab_clear_a: assert property (
    is_ab |=> bank_r == drf_pkg::BANK_RESET)
    else $error("all-bank refresh did not clear counter");
  sync_clear_a: assert property (
    (i_reset_cmd || i_self_refresh_exit) |=> bank_r == drf_pkg::BANK_RESET)
    else $error("counter not cleared on reset or exit");
  decode_pulse_a: assert property (
    (!i_cs_n && i_cmd_addr == 4'hc) |=> o_all_bank_refresh)
    else $error("all-bank decode missed");
  pb_pulse_a: assert property (
    is_pb |=> o_per_bank_refresh && !o_all_bank_refresh)
    else $error("per-bank decode missed");
  ab_pulse_a: assert property (
    is_ab |=> o_all_bank_refresh && !o_per_bank_refresh)
    else $error("all-bank decode gave wrong kind");
  no_false_a: assert property (
    i_cs_n |=> !o_per_bank_refresh && !o_all_bank_refresh)
    else $error("refresh decoded without chip select");
  pb_target_a: assert property (
    is_pb |=> o_bank_busy[$past(bank_r)])
    else $error("per-bank refresh hit the wrong bank");
  pb_busy_a: assert property (
    start_w[0] |=> pb_cycle0_s)
    else $error("bank 0 busy time wrong");
  last_busy_a: assert property (
    start_w[7] |=> pb_cycle7_s)
    else $error("bank 7 busy time wrong");
  other_free_a: assert property (
    (start_w[1] && !busy_w[0]) |=> !o_bank_busy[0])
    else $error("unrefreshed bank marked busy");
  pb_no_all_a: assert property (
    (is_pb && state_r == DRF_IDLE) |=> !o_all_refresh_busy)
    else $error("per-bank refresh took the whole device");
  ab_start_a: assert property (
    is_ab |=> o_all_refresh_busy)
    else $error("all-bank busy did not start");
  ab_done_a: assert property (
    (is_ab && state_r == DRF_IDLE) |=> ab_cycle_s)
    else $error("all-bank busy time wrong");
endmodule

// *** logic/drf_pkg.sv ***
// Package for the refresh command decoder and bank scheduler.
// Assumes one 40 MHz clock; timing constants are in ns with derived counts.
package drf_pkg;
  // ==========================================================================
  // Bank geometry
  localparam int         NUM_BANKS   = 8;
  localparam logic [2:0] BANK_RESET  = 3'h0;
  localparam logic [2:0] BANK_LAST   = 3'h7;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int T_RFC_ALL_NS    = 130;
  localparam int T_RFC_BANK_NS   = 60;
  localparam int RFC_ALL_CYC     = (T_RFC_ALL_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam int RFC_BANK_CYC    = (T_RFC_BANK_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
  localparam logic [7:0] RFC_ALL_CNT  = 8'(RFC_ALL_CYC);
  localparam logic [7:0] RFC_BANK_CNT = 8'(RFC_BANK_CYC);
  // ==========================================================================
  // Command pin positions
  localparam int CA_BIT0 = 0;
  localparam int CA_BIT1 = 1;
  localparam int CA_BIT2 = 2;
  localparam int CA_BIT3 = 3;
endpackage

// *** logic/drf_bank_timer.sv ***
// One bank's refresh busy timer.
// Assumes the start pulse and load count come from the scheduler.
`timescale 1ns/10ps
module drf_bank_timer (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_start,
  input  wire logic [7:0] i_count,
  output logic            o_busy
);
  logic [7:0] cnt_r;
  // ==========================================================================
  // Countdown; bank idle again when it reaches zero
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_r <= 8'h00;
    end else if (i_start) begin
      // Start edge is the first busy cycle, so one count less remains
      cnt_r <= i_count - 8'h01;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign o_busy = (cnt_r != 8'h00);
endmodule

// *** verification/drf_ctrl_model.sv ***
// Controller-side command driver for the refresh scheduler bench.
// Assumes the bench owns the clock and calls issue() between commands.
`timescale 1ns/10ps
module drf_ctrl_model (
  input  wire logic       i_clk,
  output logic            o_cs_n,
  output logic [3:0]      o_cmd_addr
);
  // Burst window for all-bank refreshes: at most eight in four times eight
  // all-bank cycles, which keeps the supply current bounded
  localparam realtime BURST_WIN_NS = 4 * 8 * drf_pkg::T_RFC_ALL_NS;
  // Controller bookkeeping of what it issued; the bench reads the counts
  int      ab_issued;
  int      pb_issued;
  realtime ab_time [8];
  // ==========================================================================
  // Idle state: deselected, address lines start on 4'ha, which is not a refresh pattern
  initial begin
    o_cs_n     = 1'b1;
    o_cmd_addr = 4'ha;
    ab_issued  = 0;
    pb_issued  = 0;
  end
  // Toggle off the sampling edge so a lost chip select cannot look valid
  always @(negedge i_clk) begin
    if (o_cs_n) o_cmd_addr <= ~o_cmd_addr;
  end
  // ==========================================================================
  // One command, held across exactly one rising edge
  // Per-bank is legal here because the part has eight banks
  task automatic issue(input logic sel_n, input logic [3:0] cmd);
    logic ab_cmd;
    ab_cmd = !sel_n && (cmd == 4'hc);
    // A ninth all-bank waits until the oldest of the last eight ages out
    if (ab_cmd && ab_issued >= 8) begin
      while ($realtime - ab_time[ab_issued % 8] < BURST_WIN_NS) begin
        @(posedge i_clk);
      end
    end
    @(posedge i_clk) #1;
    o_cs_n     = sel_n;
    o_cmd_addr = cmd;
    if (ab_cmd) begin
      ab_time[ab_issued % 8] = $realtime;
      ab_issued++;
    end
    if (!sel_n && cmd == 4'h4) pb_issued++;
    @(posedge i_clk) #1;
    o_cs_n     = 1'b1;
  endtask
endmodule

// *** verification/tb_drf_refresh_sched.sv ***
// Self-checking bench for the refresh scheduler.
// Assumes the controller model drives the command pins.
`timescale 1ns/10ps
module tb_drf_refresh_sched;
  logic       i_clk, i_sys_rst, i_reset_cmd, i_self_refresh_exit;
  logic       i_cs_n;
  logic [3:0] i_cmd_addr;
  logic [2:0] o_bank_counter;
  logic [7:0] o_bank_busy;
  logic       o_all_refresh_busy, o_per_bank_refresh, o_all_bank_refresh;
  logic [2:0] exp_bank;
  int         bad_count, check_count;
  int         pb_seen, ab_seen;
  wire  [7:0] pulse_w;
  assign pulse_w = {6'h00, o_per_bank_refresh, o_all_bank_refresh};
  drf_ctrl_model ctrl (.i_clk(i_clk), .o_cs_n(i_cs_n),
                       .o_cmd_addr(i_cmd_addr));
  drf_refresh_sched dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_cs_n(i_cs_n), .i_cmd_addr(i_cmd_addr), .i_reset_cmd(i_reset_cmd),
    .i_self_refresh_exit(i_self_refresh_exit),
    .o_bank_counter(o_bank_counter), .o_bank_busy(o_bank_busy),
    .o_all_refresh_busy(o_all_refresh_busy),
    .o_per_bank_refresh(o_per_bank_refresh),
    .o_all_bank_refresh(o_all_bank_refresh));
  // ==========================================================================
  // Clock and shared helpers
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Count decoded refreshes mid-cycle, where each one-cycle pulse is settled
  always @(negedge i_clk) begin
    if (o_per_bank_refresh === 1'b1) pb_seen++;
    if (o_all_bank_refresh === 1'b1) ab_seen++;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================================
  // One refresh; waiting out busy also keeps the controller spacing
  task automatic refresh(input logic all);
    int n;
    n = 0;
    ctrl.issue(1'b0, {all, 3'h4});
    cmp(pulse_w, 8'({~all, all}));
    cmp(o_bank_busy, all ? 8'h00 : 8'h01 << exp_bank);
    exp_bank = all ? 3'h0 : exp_bank + 3'h1;
    cmp(8'(o_bank_counter), 8'(exp_bank));
    while ((o_bank_busy !== 8'h00 || o_all_refresh_busy !== 1'b0) && n < 12)
    begin
      n++;
      @(posedge i_clk) #1;
    end
    cmp(8'(n), all ? 8'h06 : 8'h03);
    cmp(pulse_w, 8'h00);
  endtask
  // Nine per-bank refreshes walk banks 0..7 and wrap
  task automatic t_round();
    for (int i = 0; i < 9; i++) refresh(1'b0);
  endtask
  // All-bank refresh mid-round returns the counter to zero; no row is ever
  // opened here, so every bank is idle when the all-bank goes out
  task automatic t_all();
    refresh(1'b0);
    refresh(1'b0);
    refresh(1'b1);
    refresh(1'b0);
  endtask
  // Reset command and self refresh exit each clear the counter; after an
  // exit refreshes resume at once, so the rolling count keeps its pace
  task automatic t_sync(input logic use_exit);
    refresh(1'b0);
    refresh(1'b0);
    @(posedge i_clk) #1;
    if (use_exit) i_self_refresh_exit = 1'b1;
    else i_reset_cmd = 1'b1;
    @(posedge i_clk) #1;
    i_self_refresh_exit = 1'b0;
    i_reset_cmd = 1'b0;
    exp_bank = 3'h0;
    cmp(8'(o_bank_counter), 8'h00);
    refresh(1'b0);
  endtask
  // Near-miss patterns must not count as refreshes; judged in the cycle
  // right after the sampling edge, where a false pulse would stand
  task automatic t_other();
    logic [4:0] pat [5] = '{5'h14, 5'h1c, 5'h00, 5'h05, 5'h06};
    for (int i = 0; i < 5; i++) begin
      ctrl.issue(pat[i][4], pat[i][3:0]);
      cmp(pulse_w, 8'h00);
      cmp(8'(o_bank_counter), 8'(exp_bank));
      @(posedge i_clk) #1;
    end
  endtask
  // ==========================================================================
  // Watchdog and main sequence
  initial begin
    #50000;
    bad_count++;
    final_report();
  end
  initial begin
    bad_count = 0;
    check_count = 0;
    pb_seen = 0;
    ab_seen = 0;
    exp_bank = 3'h0;
    i_sys_rst = 1'b1;
    i_reset_cmd = 1'b0;
    i_self_refresh_exit = 1'b0;
    repeat (4) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    cmp(o_bank_busy, 8'h00);
    cmp(8'({o_bank_counter, o_all_refresh_busy}), 8'h00);
    t_round();
    t_all();
    t_sync(1'b0);
    t_sync(1'b1);
    t_other();
    // Every issued refresh decoded once; rounds of eight count as one
    cmp(8'(pb_seen), 8'(ctrl.pb_issued));
    cmp(8'(ab_seen), 8'(ctrl.ab_issued));
    cmp(8'(ab_seen + pb_seen / 8), 8'h03);
    final_report();
  end
endmodule
